/* common/atsr_defs.svh */
`ifndef ATSR_DEFS_SVH
`define ATSR_DEFS_SVH

// Timing base
`define ATSR_CLK_HZ 20000000
`define ATSR_BAUD_BPS 9600
`define ATSR_BIT_CYCLES (`ATSR_CLK_HZ / `ATSR_BAUD_BPS)
`define ATSR_READY_MS 100
`define ATSR_READY_CYCLES ((`ATSR_CLK_HZ / 1000) * `ATSR_READY_MS)
`define ATSR_HOLD_MS 400
`define ATSR_HOLD_CYCLES ((`ATSR_CLK_HZ / 1000) * `ATSR_HOLD_MS)

// Framing
`define ATSR_CHAR_BITS 7
`define ATSR_FRAME_TICKS 4'hB
`define ATSR_MSG_CHARS 4'h8
`define ATSR_LAST_DIGIT 3'h4
`define ATSR_FIFO_DEPTH 16

// Turn wrap limit register
`define ATSR_WRAP_RESET 16'hFFFF
`define ATSR_COUNT_MAX 16'h7FFF
`define ATSR_COUNT_MIN 16'h8000

// Message characters
`define ATSR_CH_P 7'h50
`define ATSR_CH_PLUS 7'h2B
`define ATSR_CH_MINUS 7'h2D
`define ATSR_CH_ZERO 7'h30
`define ATSR_CH_CR 7'h0D

// Decimal weights
`define ATSR_POW10_4 16'h2710
`define ATSR_POW10_3 16'h03E8
`define ATSR_POW10_2 16'h0064
`define ATSR_POW10_1 16'h000A
`define ATSR_POW10_0 16'h0001

`endif

/* common/atsr_pkg.sv */
package atsr_pkg;

   // Report sequencer states
   typedef enum logic [5:0] {
      ST_NORMAL = 6'h01,
      ST_WAIT = 6'h02,
      ST_CONV = 6'h04,
      ST_SEND = 6'h08,
      ST_HOLD = 6'h10,
      ST_ALARM = 6'h20
   } atsr_state_t;

   // One-revolution crossing events
   typedef struct packed {
      logic fwd;
      logic rev;
   } atsr_step_t;

   // Write port of the wrap limit setting
   typedef struct packed {
      logic en;
      logic [15:0] data;
   } atsr_limit_wr_t;

endpackage

/* src/atsr_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module atsr_fifo #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 16
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic clk_en, // Freezes state while low
   input wire logic in_valid, // Write request
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic in_ready, // Room for a word, registered
   output logic out_valid, // Word available
   output logic [WIDTH-1:0] out_data, // Oldest word
   input wire logic out_ready // Drain accepts word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg, rd_ptr_reg, count, count_next;
   logic push, pop;

   // Handshakes and fill level
   assign count = wr_ptr_reg - rd_ptr_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   assign count_next = count + (AW+1)'(push) - (AW+1)'(pop);

   // Pointers and registered ready
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         in_ready <= 1'b1;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         in_ready <= count_next != (AW+1)'(DEPTH);
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

endmodule

`default_nettype wire

/* src/atsr_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "atsr_defs.svh"

// Functional notes
// R1: Revolution message leaves on the phase A pulse line, pulses otherwise.
// R2: 9600 bps, start, 7 ASCII bits, even parity, stop; eight characters.
// R3: Message is P, sign, five decimal digits, carriage return.
// R4: Zero count sends five zeros with a sign; receiver takes either sign.
// R5: Default limit spans -32768..+32767 and wraps at both ends.
// R6: Incremental pulses after the message use the normal divided path.
// R7: Accepted sensor-off sends alarm contents serially on the phase A line.
// R8: Sensor-off is refused while motor power is on.
// R9: Wrap limit 0..65535, default 65535, effective after restart.
// R10: Non-default limit: reverse at zero loads the limit.
// R11: Non-default limit: forward at the limit returns to zero.
// R12: Software programs the limit as revolutions per cycle minus one.
// R13: 100 ms after sensor-on the message is ready and pulse counter cleared.
// R14: About 400 ms after the last character, normal pulses resume; the code passes pulses already in ST_HOLD, right after the last character.
// R15: Data bits go out LSB first; line idles high between characters.
module atsr_top
   import atsr_pkg::*;
#(
   parameter int BIT_CYCLES = `ATSR_BIT_CYCLES,
   parameter int READY_CYCLES = `ATSR_READY_CYCLES,
   parameter int HOLD_CYCLES = `ATSR_HOLD_CYCLES,
   parameter int FIFO_DEPTH = `ATSR_FIFO_DEPTH
) (
   input wire logic clk, // 20 MHz system clock
   input wire logic rst_b, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic sensor_on_command, // Sensor-on pulse
   input wire logic sensor_off_command, // Sensor-off pulse
   input wire logic motor_power_on, // Motor power level
   input wire logic abs_encoder_used, // Absolute encoder fitted
   input wire logic restart_req, // Restart pulse, applies limit
   input wire atsr_step_t rev_step, // Revolution crossings
   input wire logic inc_pulse_a, // Divided incremental phase A
   input wire atsr_limit_wr_t limit_wr, // Wrap limit write
   input wire logic alarm_char_valid, // Alarm character offered
   input wire logic [`ATSR_CHAR_BITS-1:0] alarm_char_data, // Alarm character
   output logic alarm_char_ready, // Alarm buffer has room
   output logic phase_a_pulse_out, // Phase A output line
   output logic inc_counter_clear, // Pulse counter clear strobe
   output logic sensor_off_refused, // Sensor-off rejected strobe
   output logic report_busy, // Sequencer not in normal
   output logic [15:0] turn_wrap_limit_setting, // Limit register readback
   output logic [15:0] rev_count // Revolution count
);
   localparam int TW = $clog2(HOLD_CYCLES + READY_CYCLES + 1);
   localparam int BW = $clog2(BIT_CYCLES + 1);

   atsr_state_t state_reg;
   logic [TW-1:0] timer_reg;
   logic [15:0] limit_active_reg, mag_reg;
   logic sign_reg;
   logic [4:0][3:0] digit_reg;
   logic [2:0] dig_idx_reg;
   logic [3:0] char_idx_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_ticks_reg;
   logic [BW-1:0] tx_baud_reg;
   logic tx_line_reg;
   logic tx_busy, tx_load, off_ok, limit_default;
   logic [`ATSR_CHAR_BITS-1:0] tx_char, msg_char, fifo_data;
   logic fifo_valid, fifo_pop;
   logic [15:0] pow_now;

   // Decimal weight for the current digit
   function automatic logic [15:0] atsr_pow10(input logic [2:0] idx);
      case (idx)
         3'h0: atsr_pow10 = `ATSR_POW10_4;
         3'h1: atsr_pow10 = `ATSR_POW10_3;
         3'h2: atsr_pow10 = `ATSR_POW10_2;
         3'h3: atsr_pow10 = `ATSR_POW10_1;
         default: atsr_pow10 = `ATSR_POW10_0;
      endcase
   endfunction

   assign limit_default = limit_active_reg == `ATSR_WRAP_RESET;
   assign pow_now = atsr_pow10(dig_idx_reg);
   assign tx_busy = tx_ticks_reg != 4'h0;
   assign off_ok = sensor_off_command && abs_encoder_used && !motor_power_on; // [R8]

   // Message character for the current index
   always_comb begin
      case (char_idx_reg)
         4'h0: msg_char = `ATSR_CH_P; // [R3]
         4'h1: msg_char = sign_reg ? `ATSR_CH_MINUS : `ATSR_CH_PLUS; // [R4]
         4'h2: msg_char = `ATSR_CH_ZERO | {3'h0, digit_reg[0]};
         4'h3: msg_char = `ATSR_CH_ZERO | {3'h0, digit_reg[1]};
         4'h4: msg_char = `ATSR_CH_ZERO | {3'h0, digit_reg[2]};
         4'h5: msg_char = `ATSR_CH_ZERO | {3'h0, digit_reg[3]};
         4'h6: msg_char = `ATSR_CH_ZERO | {3'h0, digit_reg[4]};
         default: msg_char = `ATSR_CH_CR; // [R3]
      endcase
   end

   // Character source and load strobe
   assign tx_load = !tx_busy && ((state_reg == ST_SEND && char_idx_reg != `ATSR_MSG_CHARS) ||
                                 (state_reg == ST_ALARM && fifo_valid));
   assign tx_char = (state_reg == ST_ALARM) ? fifo_data : msg_char;
   assign fifo_pop = tx_load && state_reg == ST_ALARM; // [R7]

   // Alarm character buffer
   atsr_fifo #(
      .WIDTH(`ATSR_CHAR_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_alarm_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(alarm_char_valid),
      .in_data(alarm_char_data),
      .in_ready(alarm_char_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Wrap limit setting and the copy applied at restart
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         turn_wrap_limit_setting <= `ATSR_WRAP_RESET;
         limit_active_reg <= `ATSR_WRAP_RESET;
      end else if (clk_en) begin
         if (limit_wr.en) begin
            turn_wrap_limit_setting <= limit_wr.data; // [R9]
         end
         if (restart_req) begin
            limit_active_reg <= turn_wrap_limit_setting; // [R9]
         end
      end
   end

   // Multiturn revolution counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rev_count <= 16'h0000;
      end else if (clk_en && abs_encoder_used) begin
         if (rev_step.fwd && !rev_step.rev) begin
            if (limit_default) begin
               rev_count <= rev_count + 16'h0001; // [R5]
            end else if (rev_count == limit_active_reg) begin
               rev_count <= 16'h0000; // [R11]
            end else begin
               rev_count <= rev_count + 16'h0001;
            end
         end else if (rev_step.rev && !rev_step.fwd) begin
            if (limit_default) begin
               rev_count <= rev_count - 16'h0001; // [R5]
            end else if (rev_count == 16'h0000) begin
               rev_count <= limit_active_reg; // [R10]
            end else begin
               rev_count <= rev_count - 16'h0001;
            end
         end
      end
   end

   // Report sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_NORMAL;
         timer_reg <= '0;
         char_idx_reg <= 4'h0;
      end else if (clk_en) begin
         case (state_reg)
            ST_NORMAL: begin
               timer_reg <= '0;
               char_idx_reg <= 4'h0;
               if (sensor_on_command && abs_encoder_used) begin
                  state_reg <= ST_WAIT;
               end else if (off_ok) begin
                  state_reg <= ST_ALARM; // [R7]
               end
            end
            ST_WAIT: begin
               if (timer_reg == TW'(READY_CYCLES - 1)) begin
                  timer_reg <= '0;
                  state_reg <= ST_CONV; // [R13]
               end else begin
                  timer_reg <= timer_reg + 1'b1;
               end
            end
            ST_CONV: begin
               if (mag_reg < pow_now && dig_idx_reg == `ATSR_LAST_DIGIT) begin
                  state_reg <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (tx_load) begin
                  char_idx_reg <= char_idx_reg + 4'h1;
               end else if (!tx_busy && char_idx_reg == `ATSR_MSG_CHARS) begin
                  state_reg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (timer_reg == TW'(HOLD_CYCLES - 1)) begin
                  state_reg <= ST_NORMAL; // [R14]
               end else begin
                  timer_reg <= timer_reg + 1'b1;
               end
            end
            ST_ALARM: begin
               if (!tx_busy && !tx_load && !fifo_valid) begin
                  state_reg <= ST_NORMAL;
               end
            end
            default: state_reg <= ST_NORMAL;
         endcase
      end
   end

   // Snapshot and decimal conversion by repeated subtraction
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mag_reg <= 16'h0000;
         sign_reg <= 1'b0;
         digit_reg <= '0;
         dig_idx_reg <= 3'h0;
      end else if (clk_en) begin
         if (state_reg == ST_WAIT) begin
            sign_reg <= limit_default && rev_count[15]; // [R5]
            mag_reg <= (limit_default && rev_count[15]) ? (16'h0000 - rev_count) : rev_count;
            digit_reg <= '0;
            dig_idx_reg <= 3'h0;
         end else if (state_reg == ST_CONV) begin
            if (mag_reg >= pow_now) begin
               mag_reg <= mag_reg - pow_now;
               digit_reg[dig_idx_reg] <= digit_reg[dig_idx_reg] + 4'h1;
            end else if (dig_idx_reg != `ATSR_LAST_DIGIT) begin
               dig_idx_reg <= dig_idx_reg + 3'h1;
            end
         end
      end
   end

   // Character transmitter: start, data LSB first, even parity, stop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_shift_reg <= 10'h3FF;
         tx_ticks_reg <= 4'h0;
         tx_baud_reg <= '0;
         tx_line_reg <= 1'b1;
      end else if (clk_en) begin
         if (tx_load) begin
            tx_shift_reg <= {1'b1, ^tx_char, tx_char, 1'b0}; // [R2]
            tx_ticks_reg <= `ATSR_FRAME_TICKS;
            tx_baud_reg <= '0;
         end else if (tx_busy) begin
            if (tx_baud_reg == '0) begin
               tx_line_reg <= tx_shift_reg[0]; // [R15]
               tx_shift_reg <= {1'b1, tx_shift_reg[9:1]}; // [R15]
               tx_ticks_reg <= tx_ticks_reg - 4'h1;
               tx_baud_reg <= BW'(BIT_CYCLES - 1);
            end else begin
               tx_baud_reg <= tx_baud_reg - 1'b1;
            end
         end
      end
   end

   // Output line, clear strobe and status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_a_pulse_out <= 1'b1;
         inc_counter_clear <= 1'b0;
         sensor_off_refused <= 1'b0;
         report_busy <= 1'b0;
      end else if (clk_en) begin
         case (state_reg)
            ST_WAIT, ST_CONV, ST_SEND, ST_ALARM: phase_a_pulse_out <= tx_line_reg; // [R1]
            default: phase_a_pulse_out <= inc_pulse_a; // [R6]
         endcase
         inc_counter_clear <= state_reg == ST_WAIT && timer_reg == TW'(READY_CYCLES - 1); // [R13]
         sensor_off_refused <= sensor_off_command && !off_ok; // [R8]
         report_busy <= state_reg != ST_NORMAL;
      end
   end

   a_normal_pulse_path: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      (clk_en && state_reg == ST_NORMAL) |=> phase_a_pulse_out == $past(inc_pulse_a))
      else $error("phase A line does not follow pulses in normal state");

   a_frame_parity_even: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      (tx_ticks_reg == `ATSR_FRAME_TICKS && tx_baud_reg == '0) |->
         (tx_shift_reg[0] == 1'b0 && tx_shift_reg[9] && ^tx_shift_reg[8:1] == 1'b0))
      else $error("loaded frame has bad start, stop or parity");

   a_start_bit_low: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
      (clk_en && tx_busy && tx_ticks_reg == `ATSR_FRAME_TICKS && tx_baud_reg == '0) |=>
         !tx_line_reg)
      else $error("start bit not driven low");

   a_message_ends_cr: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
      (tx_load && state_reg == ST_SEND && char_idx_reg == 4'h7) |-> tx_char == `ATSR_CH_CR)
      else $error("last message character is not carriage return");

   a_zero_digits: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
      (state_reg == ST_SEND && $past(state_reg) == ST_CONV && $past(rev_count) == 16'h0000) |->
         (digit_reg == '0 && !sign_reg))
      else $error("zero count did not give five zero digits");

   a_default_wrap_up: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
      (clk_en && abs_encoder_used && limit_default && rev_step == 2'b10 &&
         rev_count == `ATSR_COUNT_MAX) |=> rev_count == `ATSR_COUNT_MIN)
      else $error("count did not wrap from maximum to minimum");

   a_limit_wrap_down: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
      (clk_en && abs_encoder_used && !limit_default && rev_step == 2'b01 &&
         rev_count == 16'h0000) |=> rev_count == $past(limit_active_reg))
      else $error("reverse at zero did not load the limit");

   a_limit_wrap_up: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
      (clk_en && abs_encoder_used && !limit_default && rev_step == 2'b10 &&
         rev_count == limit_active_reg) |=> rev_count == 16'h0000)
      else $error("forward at limit did not return to zero");

   a_limit_on_restart: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
      $changed(limit_active_reg) |-> $past(restart_req) && $past(clk_en))
      else $error("active limit changed without restart");

   a_off_refused_power: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
      (clk_en && sensor_off_command && motor_power_on) |=> sensor_off_refused && state_reg != ST_ALARM)
      else $error("sensor-off taken while motor power on");

   a_off_enters_alarm: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
      (clk_en && state_reg == ST_NORMAL && !sensor_on_command && off_ok) |=> state_reg == ST_ALARM)
      else $error("accepted sensor-off did not start alarm report");

   a_clear_before_conv: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
      $rose(inc_counter_clear) |-> state_reg == ST_CONV)
      else $error("counter clear not at end of ready delay");

   a_hold_then_normal: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
      (clk_en && state_reg == ST_HOLD && timer_reg == TW'(HOLD_CYCLES - 1)) |=> state_reg == ST_NORMAL)
      else $error("hold interval did not end in normal output");

endmodule

`default_nettype wire

/* bench/atsr_host_rx.sv */
`timescale 1ns/100ps
`default_nettype none

module atsr_host_rx #(
   parameter int BIT_CYCLES = 8
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic listen, // Receiver armed
   input wire logic line_in, // Phase A line from the device
   output logic rx_valid, // One-cycle character strobe
   output logic [6:0] rx_char, // Received character
   output logic rx_err // Sticky parity or stop fault
);
   int cnt_reg;
   int bit_reg;
   logic busy_reg;
   logic [8:0] sh_reg;

   // Start detect, mid-bit sampling, data taken LSB first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 0;
         bit_reg <= 0;
         busy_reg <= 1'h0;
         sh_reg <= 9'h000;
         rx_valid <= 1'h0;
         rx_char <= 7'h00;
         rx_err <= 1'h0;
      end else begin
         rx_valid <= 1'h0;
         if (!busy_reg) begin
            if (listen && !line_in) begin
               busy_reg <= 1'h1;
               cnt_reg <= BIT_CYCLES / 2;
               bit_reg <= 0;
            end
         end else if (cnt_reg > 1) begin
            cnt_reg <= cnt_reg - 1;
         end else if (bit_reg < 9) begin
            cnt_reg <= BIT_CYCLES;
            sh_reg <= {line_in, sh_reg[8:1]};
            bit_reg <= bit_reg + 1;
            busy_reg <= !(bit_reg == 0 && line_in);
         end else begin
            busy_reg <= 1'h0;
            rx_valid <= 1'h1;
            rx_char <= sh_reg[7:1];
            rx_err <= rx_err | (^sh_reg[8:1]) | !line_in;
         end
      end
   end
endmodule

`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench
   import atsr_pkg::*;
;
   localparam int BIT = 8;
   localparam int RDY = 20;
   localparam int HLD = 40;
   typedef struct packed {
      logic ab;
      logic wr;
      logic [15:0] wd;
      logic rs;
      logic [1:0] st;
      logic [15:0] cnt;
      logic [15:0] set;
   } atsr_row_t;
   logic clk, rst_b, sensor_on_command, sensor_off_command, motor_power_on, abs_encoder_used;
   logic restart_req, inc_pulse_a, alarm_char_valid, alarm_char_ready, phase_a_pulse_out;
   logic inc_counter_clear, sensor_off_refused, report_busy, rx_on, rx_valid, rx_err;
   logic [6:0] alarm_char_data, rx_char;
   logic [15:0] turn_wrap_limit_setting, rev_count;
   atsr_step_t rev_step;
   atsr_limit_wr_t limit_wr;
   logic [6:0] rxq [$];
   int bad_count, checked, cyc, k;
   // Steps, writes and restarts with the count and readback they give
   atsr_row_t rows [0:21] = '{
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'hffff, 16'hffff},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'hffff},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h3, 16'h0000, 16'hffff},
      '{1'h1, 1'h1, 16'h0063, 1'h0, 2'h0, 16'h0000, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'hffff, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h1, 2'h0, 16'h0000, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'h0063, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'h0063, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'h0062, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0063, 16'h0063},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'h0063},
      '{1'h1, 1'h1, 16'h0000, 1'h0, 2'h0, 16'h0000, 16'h0000},
      '{1'h1, 1'h0, 16'h0000, 1'h1, 2'h0, 16'h0000, 16'h0000},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'h0000},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'h0000, 16'h0000},
      '{1'h1, 1'h1, 16'hffff, 1'h0, 2'h0, 16'h0000, 16'hffff},
      '{1'h1, 1'h0, 16'h0000, 1'h1, 2'h0, 16'h0000, 16'hffff},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h1, 16'hffff, 16'hffff},
      '{1'h1, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'hffff},
      '{1'h0, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0000, 16'hffff}
   };

   atsr_top #(.BIT_CYCLES(BIT), .READY_CYCLES(RDY), .HOLD_CYCLES(HLD), .FIFO_DEPTH(16)) atsr_top_inst (
      .clk(clk), .rst_b(rst_b), .clk_en(1'h1), .sensor_on_command(sensor_on_command),
      .sensor_off_command(sensor_off_command), .motor_power_on(motor_power_on),
      .abs_encoder_used(abs_encoder_used), .restart_req(restart_req), .rev_step(rev_step),
      .inc_pulse_a(inc_pulse_a), .limit_wr(limit_wr), .alarm_char_valid(alarm_char_valid),
      .alarm_char_data(alarm_char_data), .alarm_char_ready(alarm_char_ready),
      .phase_a_pulse_out(phase_a_pulse_out), .inc_counter_clear(inc_counter_clear),
      .sensor_off_refused(sensor_off_refused), .report_busy(report_busy),
      .turn_wrap_limit_setting(turn_wrap_limit_setting), .rev_count(rev_count));

   atsr_host_rx #(.BIT_CYCLES(BIT)) atsr_host_rx_inst (
      .clk(clk), .rst_b(rst_b), .listen(rx_on), .line_in(phase_a_pulse_out),
      .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err));

   // Clock, character capture and run ceiling
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (rx_valid === 1'h1)
         rxq.push_back(rx_char);
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         $display("wrong value at %0t: run ceiling reached", $time);
         end_sim();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic step_n(input logic [1:0] s, input int n);
      @(posedge clk) rev_step <= s;
      repeat (n - 1) @(posedge clk);
      @(posedge clk) rev_step <= 2'h0;
      @(negedge clk);
   endtask

   // One-cycle sensor-on or sensor-off pulse, returns just after the taking edge
   task automatic cmd(input logic off);
      @(posedge clk) begin
         sensor_on_command <= !off;
         sensor_off_command <= off;
      end
      @(posedge clk) begin
         sensor_on_command <= 1'h0;
         sensor_off_command <= 1'h0;
      end
      #1;
   endtask

   task automatic report(input string s);
      int n;
      realtime t0;
      rxq.delete();
      cmd(1'h0);
      @(posedge clk) #1 check(report_busy, 1, "busy after sensor-on");
      for (n = 1; n < 100 && inc_counter_clear !== 1'h1; n++) begin
         @(posedge clk);
         #1;
      end
      check(n, RDY, "ready delay");
      check(phase_a_pulse_out, 1, "idle line before message");
      for (n = 0; n < 2000 && rxq.size() < 8; n++) @(posedge clk);
      t0 = $realtime;
      repeat (2 * BIT) @(posedge clk);
      rx_on <= 1'h0;
      inc_pulse_a <= 1'h0;
      repeat (2) @(posedge clk);
      #1 check(phase_a_pulse_out, 0, "pulses pass in hold");
      @(posedge clk) inc_pulse_a <= 1'h1;
      for (n = 0; n < 500 && report_busy === 1'h1; n++) @(posedge clk);
      n = int'(($realtime - t0) / 50.0);
      check(16'(n >= HLD && n <= HLD + BIT + 4), 1, "hold length");
      check(16'(rxq.size()), 8, "char count");
      for (n = 0; n < 7; n++) check(rxq[n], 16'(s[n]), "message char");
      check(rxq[7], 16'h000d, "closing char");
      check(rx_err, 0, "framing");
      @(posedge clk) rx_on <= 1'h1;
      $display("test report %s done", s);
   endtask

   initial begin
      clk = 1'h0;
      rst_b = 1'h0;
      {sensor_on_command, sensor_off_command, motor_power_on, restart_req} = 4'h0;
      {abs_encoder_used, inc_pulse_a, rx_on} = 3'h7;
      rev_step = 2'h0;
      limit_wr = 17'h0_0000;
      alarm_char_valid = 1'h0;
      alarm_char_data = 7'h00;
      repeat (5) @(posedge clk);
      check(turn_wrap_limit_setting, 16'hffff, "reset limit");
      check(rev_count, 0, "reset count");
      check(phase_a_pulse_out, 1, "reset line");
      rst_b <= 1'h1;
      // Table of counting cases, one row per cycle pair
      foreach (rows[i]) begin
         @(posedge clk) begin
            abs_encoder_used <= rows[i].ab;
            limit_wr <= {rows[i].wr, rows[i].wd};
            restart_req <= rows[i].rs;
            rev_step <= rows[i].st;
         end
         @(posedge clk) begin
            abs_encoder_used <= 1'h1;
            limit_wr <= 17'h0_0000;
            restart_req <= 1'h0;
            rev_step <= 2'h0;
         end
         @(negedge clk);
         check(rev_count, rows[i].cnt, "row count");
         check(turn_wrap_limit_setting, rows[i].set, "row limit");
      end
      $display("test table done");
      // Wrap at both ends of the signed range
      step_n(2'h1, 32768);
      check(rev_count, 16'h8000, "count at minimum");
      step_n(2'h1, 1);
      check(rev_count, 16'h7fff, "wrap down");
      report("P+32767");
      step_n(2'h2, 1);
      check(rev_count, 16'h8000, "wrap up");
      report("P-32768");
      // Alarm buffer filled until it refuses
      k = 0;
      @(posedge clk) begin
         alarm_char_valid <= 1'h1;
         alarm_char_data <= 7'h41;
      end
      while (k < 20) begin
         @(posedge clk);
         if (alarm_char_ready !== 1'h1)
            break;
         k++;
         alarm_char_data <= 7'h41 + 7'(k);
      end
      alarm_char_valid <= 1'h0;
      check(16'(k), 16, "buffer depth");
      motor_power_on <= 1'h1;
      cmd(1'h1);
      check(sensor_off_refused, 1, "refused with power on");
      check(report_busy, 0, "no report with power on");
      @(posedge clk) motor_power_on <= 1'h0;
      rxq.delete();
      cmd(1'h1);
      @(posedge clk) #1 check(report_busy, 1, "alarm report started");
      for (k = 0; k < 5000 && report_busy === 1'h1; k++) @(posedge clk);
      check(16'(rxq.size()), 16, "alarm char count");
      for (k = 0; k < 16 && k < rxq.size(); k++) check(rxq[k], 16'h0041 + 16'(k), "alarm char");
      check(rx_err, 0, "alarm framing");
      $display("test alarm done");
      // Reset in mid-run restores the limit and clears the count
      @(posedge clk) limit_wr <= {1'h1, 16'h1234};
      @(posedge clk) limit_wr <= 17'h0_0000;
      #1 check(turn_wrap_limit_setting, 16'h1234, "limit written");
      @(posedge clk) rst_b <= 1'h0;
      #1 check(turn_wrap_limit_setting, 16'hffff, "limit after reset");
      check(rev_count, 0, "count after reset");
      check(report_busy, 0, "idle after reset");
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      $display("test mid reset done");
      report("P+00000");
      end_sim();
   end
endmodule

`default_nettype wire
